// ---- design/uart_rx_pkg.sv ----
// uart_rx_pkg: register map, field layout, reset values and carriers
// for the receive-format and baud-divisor block.
// assumes a single 100 MHz clock and an AHB-Lite register bus.
package uart_rx_pkg;

    // register byte offsets
    localparam logic [7:0] ADDR_RX_DATA      = 8'h00;
    localparam logic [7:0] ADDR_FLAGS        = 8'h18;
    localparam logic [7:0] ADDR_RX_LINE_CTRL = 8'h1c;
    localparam logic [7:0] ADDR_BAUD_INT     = 8'h24;
    localparam logic [7:0] ADDR_BAUD_FRAC    = 8'h28;
    localparam logic [7:0] ADDR_PORT_CTRL    = 8'h30;

    // rx_line_control field positions
    localparam int POS_PARITY_ENABLE = 1;
    localparam int POS_EVEN_SELECT   = 2;
    localparam int POS_TWO_STOP      = 3;
    localparam int POS_FIFO_ENABLE   = 4;
    localparam int POS_WLEN_LO       = 5;
    localparam int POS_STICK_PARITY  = 7;
    // port_control_word field position
    localparam int POS_OVERSAMPLE    = 3;
    // flag register field positions
    localparam int POS_OVERRUN       = 0;
    localparam int POS_RX_EMPTY      = 4;
    localparam int POS_RX_FULL       = 6;

    // reset values
    localparam logic [7:0]  RST_LINE_CTRL = 8'h00;
    localparam logic [15:0] RST_BAUD_INT  = 16'h0000;
    localparam logic [5:0]  RST_BAUD_FRAC = 6'h00;

    // last sample tick index of a bit, fifo depth and pointer width
    localparam logic [3:0] TICKS_MAX_X16 = 4'hf;
    localparam logic [3:0] TICKS_MAX_X8  = 4'h7;
    localparam int         FIFO_DEPTH    = 16;
    localparam int         PTR_W         = 4;

    // AHB transfer type bit that marks an active transfer
    localparam int HTRANS_ACTIVE_BIT = 1;

    typedef struct packed {
        logic       stick_parity;
        logic [1:0] word_length;
        logic       fifo_enable;
        logic       two_stop;
        logic       even_select;
        logic       parity_enable;
        logic       spare;
    } rx_format_type;

    typedef struct packed {
        logic       frame_error;
        logic       parity_error;
        logic [7:0] data;
    } rx_char_type;

    typedef struct packed {
        logic [15:0] integer_part;
        logic [5:0]  fraction_part;
    } divisor_type;

endpackage

// ---- design/uart_baud_tick.sv ----
// uart_baud_tick: fractional baud divider, one-cycle sample tick.
// assumes the divisor input only changes between characters.
`timescale 1ns/1ps
`default_nettype none
module uart_baud_tick
    import uart_rx_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire uart_rx_pkg::divisor_type divisor,
    output logic                         tick
);
    logic [15:0] count;
    logic [5:0]  frac_acc;
    logic [6:0]  frac_sum;
    logic        enabled;

    // the carry out of the sixty-fourths accumulator stretches one period
    assign frac_sum = {1'b0, frac_acc} + {1'b0, divisor.fraction_part};
    assign enabled  = divisor.integer_part != 16'h0000;
    assign tick     = enabled && count == 16'h0000;

    // period is integer_part cycles, plus one whenever the fraction carries
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count    <= 16'h0000;
            frac_acc <= 6'h00;
        end else if (!enabled) begin
            count    <= 16'h0000;
            frac_acc <= 6'h00;
        end else if (tick) begin
            frac_acc <= frac_sum[5:0];
            count    <= divisor.integer_part - 16'h0001 + {15'h0000, frac_sum[6]};
        end else if (count > divisor.integer_part) begin
            // a shorter divisor written while idle cuts the stale period short
            count    <= divisor.integer_part - 16'h0001;
        end else begin
            count    <= count - 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ---- design/uart_rx_buffer.sv ----
// uart_rx_buffer: receive store, sixteen deep or a single holding slot.
// assumes push and pop come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module uart_rx_buffer
    import uart_rx_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    fifo_mode,
    input  wire logic                    push,
    input  wire uart_rx_pkg::rx_char_type push_char,
    input  wire logic                    pop,
    output uart_rx_pkg::rx_char_type     head_char,
    output logic                         empty,
    output logic                         full
);
    rx_char_type      store [FIFO_DEPTH];
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W:0]   level;
    logic             do_push;
    logic             do_pop;

    // character mode caps the level at one entry
    assign empty     = level == '0;
    assign full      = fifo_mode ? level == (PTR_W+1)'(FIFO_DEPTH) : level != '0;
    assign do_push   = push && !full;
    assign do_pop    = pop && !empty;
    assign head_char = store[rd_ptr];

    // pointers and level; a push into a full store is dropped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            level  <= '0;
        end else begin
            if (do_push) wr_ptr <= wr_ptr + PTR_W'(1);
            if (do_pop)  rd_ptr <= rd_ptr + PTR_W'(1);
            level <= level + (PTR_W+1)'(do_push) - (PTR_W+1)'(do_pop);
        end
    end

    // storage array, no reset needed on the data
    always_ff @(posedge clk) begin
        if (do_push) store[wr_ptr] <= push_char;
    end
endmodule
`default_nettype wire

// ---- design/uart_rx_port.sv ----
// uart_rx_port: serial receiver with programmable frame format and
// fractional baud divisor, registers over AHB-Lite.
// assumes the receive line is asynchronous and the bus runs on clk.
//
// Notes on behaviour
// - parity enable 0 means no parity bit; 1 means a parity bit is checked
// - parity checks odd ones when even-select is 0, even when it is 1
// - stick parity expects 0 with even-select 1, 1 with even-select 0
// - two-stop select 0 checks one stop bit, 1 checks two
// - fifo enable 0 gives one holding slot, 1 buffers in the fifo
// - word length code 00..11 gives five to eight data bits
// - sixteen-bit writable integer part of the baud divisor
// - oversample select 0 gives sixteen ticks per bit
// - oversample select 1 gives eight ticks per bit
// - new divisor values apply only after the current character ends
// - six-bit writable fractional part used with the integer part
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module uart_rx_port
    import uart_rx_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        rx_line,
    output logic             rx_frame_done
);
    import uart_rx_pkg::*;

    // receive states, one-hot
    typedef enum logic [4:0] {
        RX_IDLE   = 5'b00001,
        RX_START  = 5'b00010,
        RX_DATA   = 5'b00100,
        RX_PARITY = 5'b01000,
        RX_STOP   = 5'b10000
    } rx_state_type;

    // number of data bits for a word length code
    function automatic logic [3:0] data_bits(input logic [1:0] code);
        return 4'h5 + {2'b00, code};
    endfunction

    // -------- bus side state --------
    rx_format_type line_ctrl;
    logic [15:0]   baud_int;
    logic [5:0]    baud_frac;
    logic          oversample_select;
    logic          overrun;
    logic          dphase_write;
    logic          dphase_read;
    logic          read_wait;
    logic [7:0]    dphase_addr;

    // -------- receiver state --------
    rx_state_type  state;
    rx_state_type  next_state;
    divisor_type   active_div;
    logic          active_ovs;
    rx_format_type frame_fmt;
    logic [3:0]    tick_cnt;
    logic [3:0]    bit_cnt;
    logic [7:0]    shift;
    logic          parity_bit;
    logic          stop_error;
    logic          sync_0;
    logic          sync_1;
    logic          tick;

    // -------- buffer wiring --------
    rx_char_type   head_char;
    rx_char_type   push_char;
    logic          buf_empty;
    logic          buf_full;
    logic          push;
    logic          pop;

    // -------- bus decode --------
    wire        addr_phase   = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;
    wire        take_write   = addr_phase && hwrite;
    wire        take_read    = addr_phase && !hwrite;

    // data-phase register hits
    wire        wr_line      = dphase_write && dphase_addr == ADDR_RX_LINE_CTRL;
    wire        wr_int       = dphase_write && dphase_addr == ADDR_BAUD_INT;
    wire        wr_frac      = dphase_write && dphase_addr == ADDR_BAUD_FRAC;
    wire        wr_port      = dphase_write && dphase_addr == ADDR_PORT_CTRL;
    wire        wr_flags     = dphase_write && dphase_addr == ADDR_FLAGS;

    // capture on the stall cycle so hrdata stands when hreadyout rises
    wire        rd_capture   = dphase_read && !read_wait;
    wire        rd_data_reg  = rd_capture && dphase_addr == ADDR_RX_DATA;

    // -------- receiver decode --------
    wire [3:0]  bit_last     = active_ovs ? TICKS_MAX_X8 : TICKS_MAX_X16;
    wire [3:0]  bit_half     = {1'b0, bit_last[3:1]};
    wire        at_mid       = tick && tick_cnt == bit_half;
    wire        at_end       = tick && tick_cnt == bit_last;

    // synchronised level and the frozen frame shape
    wire        rx_level     = sync_1;
    wire [3:0]  word_bits    = data_bits(frame_fmt.word_length);
    wire        last_data    = bit_cnt == word_bits - 4'h1;
    wire        last_stop    = frame_fmt.two_stop ? bit_cnt == 4'h1 : 1'b1;
    wire [7:0]  aligned_data = shift >> (4'h8 - word_bits);

    // parity: a stick bit, or the ones count of data plus parity
    wire        ones_odd     = ^{aligned_data, parity_bit};
    wire        stick_expect = !frame_fmt.even_select;
    wire        parity_fault = !frame_fmt.parity_enable ? 1'b0 :
                               frame_fmt.stick_parity ?
                               parity_bit != stick_expect :
                               frame_fmt.even_select ? ones_odd : !ones_odd;

    // a character closes at the middle of its last stop bit
    wire        char_done    = state == RX_STOP && at_mid && last_stop;
    wire        idle_now     = state == RX_IDLE;

    // -------- bus outputs --------
    // reads take one wait so that the fifo pop and the data line up
    assign hreadyout = !(dphase_read && !read_wait);
    // never an error response
    assign hresp     = 1'b0;

    // a data read pops the buffer, a finished character pushes it
    assign pop       = rd_data_reg;
    assign push      = char_done;
    assign push_char = '{frame_error:  stop_error || !rx_level,
                         parity_error: parity_fault,
                         data:         aligned_data};

    // address phase capture
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dphase_write <= 1'b0;
            dphase_read  <= 1'b0;
            dphase_addr  <= 8'h00;
        end else if (hreadyout) begin
            dphase_write <= take_write;
            dphase_read  <= take_read;
            dphase_addr  <= haddr[7:0];
        end
    end

    // one-cycle wait flag for reads
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            read_wait <= 1'b0;
        end else begin
            read_wait <= dphase_read && !read_wait;
        end
    end

    // software-written format and divisor registers
    // bits above each field are ignored on write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            line_ctrl         <= rx_format_type'(RST_LINE_CTRL);
            baud_int          <= RST_BAUD_INT;
            baud_frac         <= RST_BAUD_FRAC;
            oversample_select <= 1'b0;
        end else begin
            if (wr_line) line_ctrl <= rx_format_type'(hwdata[7:0]);
            if (wr_int)  baud_int  <= hwdata[15:0];
            if (wr_frac) baud_frac <= hwdata[5:0];
            if (wr_port) oversample_select <= hwdata[POS_OVERSAMPLE];
        end
    end

    // overrun is sticky; a new overrun beats a clear in the same cycle
    // the flag clears only by writing one to its bit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overrun <= 1'b0;
        end else if (push && buf_full) begin
            overrun <= 1'b1;
        end else if (wr_flags && hwdata[POS_OVERRUN]) begin
            overrun <= 1'b0;
        end
    end

    // read data mux, registered in the first data-phase cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_capture) begin
            case (dphase_addr)
                ADDR_RX_DATA:
                    hrdata <= buf_empty ? 32'h0000_0000 : {22'h00_0000, head_char};
                ADDR_FLAGS: begin
                    hrdata <= 32'h0000_0000;
                    hrdata[POS_OVERRUN]  <= overrun;
                    hrdata[POS_RX_EMPTY] <= buf_empty;
                    hrdata[POS_RX_FULL]  <= buf_full;
                end
                ADDR_RX_LINE_CTRL: hrdata <= {24'h00_0000, line_ctrl};
                ADDR_BAUD_INT:     hrdata <= {16'h0000, baud_int};
                ADDR_BAUD_FRAC:    hrdata <= {26'h000_0000, baud_frac};
                ADDR_PORT_CTRL: begin
                    hrdata <= 32'h0000_0000;
                    hrdata[POS_OVERSAMPLE] <= oversample_select;
                end
                default:           hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // two-flop synchroniser on the receive pin
    // only the second flop feeds the receiver logic
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_0 <= 1'b1;
            sync_1 <= 1'b1;
        end else begin
            sync_0 <= rx_line;
            sync_1 <= sync_0;
        end
    end

    // divisor and rate only reload between characters, so a bit never
    // stretches or shrinks halfway through a frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_div <= '{integer_part: RST_BAUD_INT, fraction_part: RST_BAUD_FRAC};
            active_ovs <= 1'b0;
        end else if (idle_now) begin
            active_div <= '{integer_part: baud_int, fraction_part: baud_frac};
            active_ovs <= oversample_select;
        end
    end

    uart_baud_tick u_baud_tick (
        .clk     (clk),
        .rst_n   (rst_n),
        .divisor (active_div),
        .tick    (tick)
    );

    // receive state transitions
    always_comb begin
        next_state = state;
        case (state)
            RX_IDLE:   if (tick && !rx_level) next_state = RX_START;
            RX_START:  if (at_mid) next_state = rx_level ? RX_IDLE : RX_DATA;
            RX_DATA:   if (at_mid && last_data)
                           next_state = frame_fmt.parity_enable ? RX_PARITY : RX_STOP;
            RX_PARITY: if (at_mid) next_state = RX_STOP;
            RX_STOP:   if (at_mid && last_stop) next_state = RX_IDLE;
            default:   next_state = RX_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= RX_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // tick counter: phase within a bit, restarted on the start edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= 4'h0;
        end else if (idle_now) begin
            tick_cnt <= 4'h1;
        end else if (at_end) begin
            tick_cnt <= 4'h0;
        end else if (tick) begin
            tick_cnt <= tick_cnt + 4'h1;
        end
    end

    // format is frozen at the start bit so mid-frame writes cannot tear it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_fmt <= rx_format_type'(RST_LINE_CTRL);
        end else if (idle_now) begin
            frame_fmt <= line_ctrl;
        end
    end

    // bit sampling at the middle of each bit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt    <= 4'h0;
            shift      <= 8'h00;
            parity_bit <= 1'b0;
            stop_error <= 1'b0;
        end else if (at_mid) begin
            case (state)
                RX_START: begin
                    bit_cnt    <= 4'h0;
                    stop_error <= 1'b0;
                end
                RX_DATA: begin
                    shift   <= {rx_level, shift[7:1]};             // lsb first
                    bit_cnt <= last_data ? 4'h0 : bit_cnt + 4'h1;
                end
                RX_PARITY: parity_bit <= rx_level;
                RX_STOP: begin
                    stop_error <= stop_error || !rx_level;
                    bit_cnt    <= bit_cnt + 4'h1;
                end
                default: bit_cnt <= bit_cnt;
            endcase
        end
    end

    // completion pulse for the surrounding logic
    // it follows the push, so the data is readable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_frame_done <= 1'b0;
        end else begin
            rx_frame_done <= char_done;
        end
    end

    uart_rx_buffer u_rx_buffer (
        .clk       (clk),
        .rst_n     (rst_n),
        .fifo_mode (line_ctrl.fifo_enable),
        .push      (push),
        .push_char (push_char),
        .pop       (pop),
        .head_char (head_char),
        .empty     (buf_empty),
        .full      (buf_full)
    );

endmodule
`default_nettype wire

// ---- bench/uart_rx_port_chk.sv ----
// uart_rx_port_chk: bus timing and frame pulse checks for uart_rx_port.
// assumes one clock and a single slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
`default_nettype none
module uart_rx_port_chk (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        rx_frame_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // cycles since the last frame end, saturating so idle time never wraps
    logic [7:0] gap;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) gap <= 8'hff;
        else if (rx_frame_done) gap <= 8'h00;
        else if (gap != 8'hff) gap <= gap + 8'h01;
    end

    // transfer steps seen on the bus
    sequence rd_take; hsel && htrans[1] && hready && !hwrite; endsequence
    sequence wr_take; hsel && htrans[1] && hready && hwrite; endsequence
    sequence one_wait; !hreadyout ##1 hreadyout; endsequence

    chk_okay_only: assert property (hresp == 1'b0)
        else $error("error response on the bus");
    chk_read_wait: assert property (rd_take |=> one_wait)
        else $error("read data phase not exactly one wait");
    chk_write_nowait: assert property (wr_take |=> hreadyout)
        else $error("write data phase stalled");
    chk_idle_ready: assert property (!(hsel && htrans[1] && hready) |=> hreadyout)
        else $error("stall without a transfer");
    chk_stall_cause: assert property ($fell(hreadyout) |-> $past(hsel) && !$past(hwrite))
        else $error("stall not caused by a read");
    chk_rdata_hold: assert property (!$stable(hrdata) |-> $past(hreadyout) == 1'b0)
        else $error("read data moved outside a read");
    chk_done_pulse: assert property (rx_frame_done |=> !rx_frame_done [*8])
        else $error("frame end pulse too long");
    chk_frame_gap: assert property (rx_frame_done |-> gap >= 8'd48)
        else $error("frames closer than the shortest frame");
endmodule

bind uart_rx_port uart_rx_port_chk uart_rx_port_chk_i (.clk, .rst_n, .hsel, .htrans,
    .hwrite, .hready, .hreadyout, .hresp, .hrdata, .rx_frame_done);
`default_nettype wire

// ---- bench/uart_serial_source.sv ----
// uart_serial_source: remote transmitter model driving the receive line.
// assumes the caller gives the bit time in clock cycles.
`timescale 1ns/1ps
`default_nettype none
module uart_serial_source (
    input  wire logic clk,
    output logic      line
);
    // the line rests high between frames
    initial line = 1'b1;

    task automatic put(input logic v, input int bc);
        line <= v;
        repeat (bc) @(posedge clk);
    endtask

    // start bit, data lsb first, optional parity, stop bits, short idle
    task automatic send(input logic [7:0] d, input int nb, input int par, input int ns,
                        input int bc, input logic bad);
        put(1'b0, bc);
        for (int i = 0; i < nb; i++) put(d[i], bc);
        if (par >= 0) put(par[0], bc);
        // a bad stop bit rises after its sample point so no false start follows
        for (int i = 0; i < ns; i++) begin
            put(!(bad && i == ns - 1), (bad && i == ns - 1) ? bc * 3 / 4 : bc);
            if (bad && i == ns - 1) put(1'b1, bc - bc * 3 / 4);
        end
        put(1'b1, 2);
    endtask
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// testbench: register and serial frame checks for uart_rx_port.
// assumes the bind in the checker file and the serial source model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import uart_rx_pkg::*;
    logic        clk    = 1'b0;
    logic        rst_n  = 1'b0;
    logic        hsel   = 1'b0;
    logic [31:0] haddr  = 32'h0000_0000;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize  = 3'b010;
    logic [31:0] hwdata = 32'h0000_0000;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        rx_line;
    logic        rx_frame_done;
    logic        rd_phase = 1'b0;
    logic [31:0] expect_q[$];
    logic [7:0]  d;
    logic [7:0]  v[3];
    logic        pb;
    logic        flip;
    logic        bad;
    int          failures = 0;
    int          checked = 0;
    int          bc = 32;

    always #5 clk = ~clk;

    uart_rx_port uart_rx_port_i (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .rx_line, .rx_frame_done);
    uart_serial_source uart_serial_source_i (.clk, .line(rx_line));

    task automatic report_and_stop();
        if (failures == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // read results are compared in bus order against the noted values
    always @(posedge clk) begin
        if (rd_phase && hreadyout === 1'b1) begin
            checked++;
            if (hrdata !== expect_q[0]) begin
                failures++;
                $display("wrong value at %0t: read %h, expected %h", $time, hrdata, expect_q[0]);
            end
            void'(expect_q.pop_front());
        end
        if (hreadyout === 1'b1) rd_phase <= hsel && htrans[1] && !hwrite;
    end

    // one single transfer; every phase is held until hready is seen high
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        xfer(a, 1'b1, wd);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expect_q.push_back(e);
        xfer(a, 1'b0, 32'h0000_0000);
    endtask

    // send one frame and wait, bounded, for the receiver to close it
    task automatic frame(input logic [7:0] fd, input int nb, input int par, input int ns,
                         input logic fbad);
        int n;
        n = 0;
        fork
            uart_serial_source_i.send(fd, nb, par, ns, bc, fbad);
            while (rx_frame_done !== 1'b1 && n < 4000) begin
                @(posedge clk);
                n++;
            end
        join
        if (n >= 4000) begin
            failures++;
            $display("wrong value at %0t: no frame end", $time);
        end
    endtask

    function automatic logic [31:0] lcr(input int wl, input int p, input int st,
                                        input logic fen);
        return {24'h00_0000, p >= 3, wl[1:0], fen, st[0], p == 2 || p == 3, p != 0, 1'b0};
    endfunction

    initial begin
        void'($urandom(32'h3378_04da));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(ADDR_RX_LINE_CTRL, 32'h0000_0000);
        rd(ADDR_BAUD_INT, 32'h0000_0000);
        rd(ADDR_BAUD_FRAC, 32'h0000_0000);
        rd(8'h40, 32'h0000_0000);
        rd(ADDR_FLAGS, 32'h0000_0010);
        d = 8'($urandom);
        wr(ADDR_BAUD_INT, {16'hffff, d, 8'h5a});
        rd(ADDR_BAUD_INT, {16'h0000, d, 8'h5a});
        wr(ADDR_BAUD_FRAC, 32'hffff_ffff);
        rd(ADDR_BAUD_FRAC, 32'h0000_003f);
        wr(ADDR_BAUD_FRAC, 32'h0000_0000);
        wr(ADDR_BAUD_INT, 32'h0000_0002);
        // every word length, parity mode and stop count, errors injected at random
        for (int wl = 0; wl < 4; wl++) begin
            for (int p = 0; p < 5; p++) begin
                for (int st = 0; st < 2; st++) begin
                    d = 8'($urandom) & ((8'h01 << (wl + 5)) - 8'h01);
                    flip = 1'($urandom);
                    bad = ($urandom_range(5, 0) == 0);
                    pb = (p == 1) ? ~^d : (p == 2) ? ^d : (p == 4);
                    wr(ADDR_RX_LINE_CTRL, lcr(wl, p, st, 1'b1));
                    rd(ADDR_RX_LINE_CTRL, lcr(wl, p, st, 1'b1));
                    frame(d, wl + 5, p == 0 ? -1 : int'(pb ^ flip), st + 1, bad);
                    rd(ADDR_RX_DATA, {22'h00_0000, bad, p != 0 && flip, d});
                end
            end
        end
        // single holding slot: second character is dropped with overrun
        for (int i = 0; i < 3; i++) v[i] = 8'($urandom);
        wr(ADDR_RX_LINE_CTRL, lcr(3, 0, 0, 1'b0));
        frame(v[0], 8, -1, 1, 1'b0);
        frame(v[1], 8, -1, 1, 1'b0);
        rd(ADDR_FLAGS, 32'h0000_0041);
        rd(ADDR_RX_DATA, {24'h00_0000, v[0]});
        rd(ADDR_RX_DATA, 32'h0000_0000);
        wr(ADDR_FLAGS, 32'h0000_0001);
        // fifo holds several characters in order
        wr(ADDR_RX_LINE_CTRL, lcr(3, 0, 0, 1'b1));
        for (int i = 0; i < 3; i++) frame(v[i], 8, -1, 1, 1'b0);
        rd(ADDR_FLAGS, 32'h0000_0000);
        for (int i = 0; i < 3; i++) rd(ADDR_RX_DATA, {24'h00_0000, v[i]});
        // eight ticks per bit halves the bit time
        wr(ADDR_PORT_CTRL, 32'h0000_0008);
        bc = 16;
        frame(v[2], 8, -1, 1, 1'b0);
        rd(ADDR_RX_DATA, {24'h00_0000, v[2]});
        wr(ADDR_PORT_CTRL, 32'h0000_0000);
        // half a clock of fraction: drift would corrupt the later bits
        wr(ADDR_BAUD_FRAC, 32'h0000_0020);
        bc = 40;
        frame(v[1], 8, -1, 1, 1'b0);
        rd(ADDR_RX_DATA, {24'h00_0000, v[1]});
        wr(ADDR_BAUD_FRAC, 32'h0000_0000);
        // divisor written mid-character applies only from the next one
        bc = 32;
        fork
            frame(v[0], 8, -1, 1, 1'b0);
            begin
                repeat (60) @(posedge clk);
                wr(ADDR_BAUD_INT, 32'h0000_0004);
            end
        join
        rd(ADDR_RX_DATA, {24'h00_0000, v[0]});
        bc = 64;
        frame(v[2], 8, -1, 1, 1'b0);
        rd(ADDR_RX_DATA, {24'h00_0000, v[2]});
        report_and_stop();
    end

    // the whole run needs about 16000 cycles
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        $display("wrong value at %0t: watchdog expired", $time);
        report_and_stop();
    end
endmodule
`default_nettype wire
